// ===== verilog/cls_pkg.sv
// shared constants, enums and carriers of the configurable logic slice
package cls_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_F_TABLE = 8'h00;
	localparam logic [7:0] OFS_G_TABLE = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// table and register widths
	localparam int TAB_W = 16;
	localparam int CFG_W = 25;
	localparam int STAT_W = 9;

	// config field positions
	localparam int CFG_F_MODE = 0;
	localparam int CFG_G_MODE = 2;
	localparam int CFG_LATCH = 4;
	localparam int CFG_SYNC = 5;
	localparam int CFG_FHI_X = 6;
	localparam int CFG_FHI_Y = 7;
	localparam int CFG_INIT_FOLLOW = 8;
	localparam int CFG_INIT_HI_X = 9;
	localparam int CFG_INIT_HI_Y = 10;
	localparam int CFG_INV_CLK = 11;
	localparam int CFG_INV_CE = 12;
	localparam int CFG_INV_FRC = 13;
	localparam int CFG_INV_OPP = 14;
	localparam int CFG_CE_USED = 15;
	localparam int CFG_OPP_EN = 16;
	localparam int CFG_BYP_X = 17;
	localparam int CFG_BYP_Y = 18;
	localparam int CFG_XSEL = 19;
	localparam int CFG_YSEL = 21;
	localparam int CFG_WIDE = 23;

	// control bits
	localparam int CTRL_GINIT = 0;

	// reset values
	localparam logic [CFG_W-1:0] CFG_RESET = 25'h0000100;
	localparam logic [TAB_W-1:0] TAB_RESET = 16'h0000;

	typedef enum logic [1:0] {MODE_LUT, MODE_RAM, MODE_SHIFT} cls_mode_e;
	typedef enum logic [1:0] {OSEL_LUT, OSEL_COMB, OSEL_SUM} cls_osel_e;
	typedef enum logic [1:0] {WIDE_SIX, WIDE_SEVEN, WIDE_EIGHT} cls_wide_e;

	// slice pins, all from outside the bus clock domain
	typedef struct packed {
		logic [3:0] f_in;
		logic [3:0] g_in;
		logic bypass_in_x;
		logic bypass_in_y;
		logic force_state_in;
		logic ce;
		logic slice_clk;
		logic ram_we;
		logic carry_in;
		logic sop_in;
		logic shift_in;
		logic fx_in0;
		logic fx_in1;
	} cls_pins_s;

	// combinational slice results, registered before leaving
	typedef struct packed {
		logic x;
		logic y;
		logic five;
		logic wide;
		logic carry;
		logic sop;
		logic shift;
	} cls_outs_s;

endpackage

// ===== verilog/cls_slice.sv
// configurable logic slice with its configuration registers on ahb-lite
//
// Overview of operation
// - each function generator is a four-input table, any function, same delay.
// - each generator works as table, sixteen-bit memory, or sixteen-bit tapped shift register.
// - two generators per slice, each with its own four inputs.
// - generator result feeds output, storage input, xor gate, carry mux and five-combiner.
// - five-input combiner joins both generators for five and some nine-input functions.
// - wide combiner acts as six, seven or eight-input stage by tile position.
// - tile has four slices in two columns, two carry chains, one shift chain.
// - storage element is either an edge flip-flop or a level latch.
// - storage input selects generator path or bypass input.
// - clock enable active high; unused enable means always enabled.
// - force input drives one or zero as the force attribute says.
// - bypass-y reverse path drives the opposite value when enabled.
// - reset and set together give the reset value.
// - init value follows force attribute by default, or is set independently.
// - set and reset are synchronous or asynchronous per slice.
// - clock, enable and set/reset are shared by both storage elements.
// - every control input has its own selectable polarity; here ram_we has no polarity select.
// - sum-chain or joins top carry output with previous sum-chain or.
// - tables and carry muxes together build wide and gates.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
module cls_slice (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// slice pins
	input wire cls_pkg::cls_pins_s pins,
	// slice results
	output cls_pkg::cls_outs_s outs,
	output logic q_x,
	output logic q_y
);

	// pin synchroniser
	cls_pkg::cls_pins_s sync1_reg;
	cls_pkg::cls_pins_s pin;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= '0;
			pin <= '0;
		end else begin
			sync1_reg <= pins;
			pin <= sync1_reg;
		end
	end

	// bus address phase capture
	logic wr_pend_reg;
	logic [7:0] wa_reg;
	logic [31:0] hrdata_reg;
	wire addr_ok = hsel & htrans[1] & hready;
	wire hsize_ok = (hsize == 3'h2);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wa_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ok & hwrite & hsize_ok;
			wa_reg <= haddr[7:0];
		end
	end

	wire wr_cfg = wr_pend_reg & (wa_reg == cls_pkg::OFS_CONFIG);
	wire wr_ctrl = wr_pend_reg & (wa_reg == cls_pkg::OFS_CONTROL);

	// configuration register
	logic [cls_pkg::CFG_W-1:0] cfg_reg;
	logic [cls_pkg::CFG_W-1:0] cfg_next;
	assign cfg_next = wr_cfg ? hwdata[cls_pkg::CFG_W-1:0] : cfg_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= cls_pkg::CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	wire latch_mode = cfg_reg[cls_pkg::CFG_LATCH];
	wire frc_sync = cfg_reg[cls_pkg::CFG_SYNC];
	wire init_follow = cfg_reg[cls_pkg::CFG_INIT_FOLLOW];
	wire ce_used = cfg_reg[cls_pkg::CFG_CE_USED];
	wire opp_en = cfg_reg[cls_pkg::CFG_OPP_EN];
	wire [1:0] xsel = cfg_reg[cls_pkg::CFG_XSEL +: 2];
	wire [1:0] ysel = cfg_reg[cls_pkg::CFG_YSEL +: 2];
	wire [1:0] wide_lvl = cfg_reg[cls_pkg::CFG_WIDE +: 2];

	// shared controls, polarity folded in by xor
	logic clk_prev_reg;
	wire clk_lvl = pin.slice_clk ^ cfg_reg[cls_pkg::CFG_INV_CLK];
	wire clk_edge = clk_lvl & ~clk_prev_reg;
	wire ce_act = ce_used ? (pin.ce ^ cfg_reg[cls_pkg::CFG_INV_CE]) : 1'b1;
	wire frc_act = pin.force_state_in ^ cfg_reg[cls_pkg::CFG_INV_FRC];
	wire opp_act = opp_en & (pin.bypass_in_y ^ cfg_reg[cls_pkg::CFG_INV_OPP]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_prev_reg <= 1'b0;
		end else begin
			clk_prev_reg <= clk_lvl;
		end
	end

	// function generators
	logic [cls_pkg::TAB_W-1:0] tab_reg [2];
	logic [cls_pkg::TAB_W-1:0] tab_next [2];
	logic [1:0] gen_out;
	logic [1:0] gen_shift_in;
	wire [3:0] gen_addr [2];
	wire [1:0] gen_wdata = {pin.bypass_in_y, pin.bypass_in_x};
	assign gen_addr[0] = pin.f_in;
	assign gen_addr[1] = pin.g_in;
	// shift chain runs f table into g table
	assign gen_shift_in = {tab_reg[0][cls_pkg::TAB_W-1], pin.shift_in};

	for (genvar g = 0; g < 2; g++) begin : gen_fg
		wire [1:0] mode = cfg_reg[(g == 0 ? cls_pkg::CFG_F_MODE : cls_pkg::CFG_G_MODE) +: 2];
		wire [7:0] ofs = (g == 0) ? cls_pkg::OFS_F_TABLE : cls_pkg::OFS_G_TABLE;
		wire bus_wr = wr_pend_reg & (wa_reg == ofs);
		wire ram_wr = (mode == cls_pkg::MODE_RAM) & clk_edge & pin.ram_we;
		wire sh_en = (mode == cls_pkg::MODE_SHIFT) & clk_edge & ce_act;
		logic [cls_pkg::TAB_W-1:0] ram_val;
		always_comb begin
			ram_val = tab_reg[g];
			ram_val[gen_addr[g]] = gen_wdata[g];
		end
		// the bus write wins over a slice-side update in the same cycle
		assign tab_next[g] = bus_wr ? hwdata[cls_pkg::TAB_W-1:0] :
			ram_wr ? ram_val :
			sh_en ? {tab_reg[g][cls_pkg::TAB_W-2:0], gen_shift_in[g]} : tab_reg[g];
		// read, tap and table lookup are one path, so delay is function-independent
		assign gen_out[g] = tab_reg[g][gen_addr[g]];
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				tab_reg[g] <= cls_pkg::TAB_RESET;
			end else begin
				tab_reg[g] <= tab_next[g];
			end
		end
	end

	// combiners, carry and sum-of-products
	wire five_c = pin.bypass_in_x ? gen_out[1] : gen_out[0];
	wire wide_lo = (wide_lvl == cls_pkg::WIDE_SIX) ? five_c : pin.fx_in0;
	wire wide_c = pin.bypass_in_y ? pin.fx_in1 : wide_lo;
	// with bypass held low, each carry stage ands its table output in
	wire carry_mid = gen_out[0] ? pin.carry_in : pin.bypass_in_x;
	wire carry_top = gen_out[1] ? carry_mid : pin.bypass_in_y;
	wire sum_x = gen_out[0] ^ pin.carry_in;
	wire sum_y = gen_out[1] ^ carry_mid;
	wire sop_c = pin.sop_in | carry_top;

	wire x_c = (xsel == cls_pkg::OSEL_COMB) ? five_c : (xsel == cls_pkg::OSEL_SUM) ? sum_x : gen_out[0];
	wire y_c = (ysel == cls_pkg::OSEL_COMB) ? wide_c : (ysel == cls_pkg::OSEL_SUM) ? sum_y : gen_out[1];

	cls_pkg::cls_outs_s outs_reg;
	cls_pkg::cls_outs_s outs_next;
	assign outs_next = '{x: x_c, y: y_c, five: five_c, wide: wide_c, carry: carry_top, sop: sop_c,
		shift: tab_reg[1][cls_pkg::TAB_W-1]};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			outs_reg <= '0;
		end else begin
			outs_reg <= outs_next;
		end
	end

	// storage elements
	logic init_pend_reg;
	logic [1:0] q_reg;
	logic [1:0] q_next;
	wire ginit = init_pend_reg | (wr_ctrl & hwdata[cls_pkg::CTRL_GINIT]);
	wire [1:0] d_gen = {y_c, x_c};
	wire [1:0] d_byp = {pin.bypass_in_y, pin.bypass_in_x};
	wire [1:0] d_sel = {cfg_reg[cls_pkg::CFG_BYP_Y], cfg_reg[cls_pkg::CFG_BYP_X]};
	wire [1:0] fhi = {cfg_reg[cls_pkg::CFG_FHI_Y], cfg_reg[cls_pkg::CFG_FHI_X]};
	wire [1:0] ihi = {cfg_reg[cls_pkg::CFG_INIT_HI_Y], cfg_reg[cls_pkg::CFG_INIT_HI_X]};
	// a latch updates all the time the clock is active, a flop only on its edge
	wire upd = (latch_mode ? clk_lvl : clk_edge) & ce_act;
	wire force_ok = frc_sync ? (latch_mode ? clk_lvl : clk_edge) : 1'b1;

	for (genvar i = 0; i < 2; i++) begin : gen_st
		wire d = d_sel[i] ? d_byp[i] : d_gen[i];
		wire f_set = (frc_act & fhi[i]) | (opp_act & ~fhi[i]);
		wire f_clr = (frc_act & ~fhi[i]) | (opp_act & fhi[i]);
		wire init_v = init_follow ? fhi[i] : ihi[i];
		// clear tested first so that reset dominates set
		assign q_next[i] = ginit ? init_v :
			(force_ok & f_clr) ? 1'b0 :
			(force_ok & f_set) ? 1'b1 :
			upd ? d : q_reg[i];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_reg <= 2'b00;
			init_pend_reg <= 1'b1;
		end else begin
			q_reg <= q_next;
			init_pend_reg <= 1'b0;
		end
	end

	// status and read data, next values read so a write is seen at once
	wire [cls_pkg::STAT_W-1:0] status = {ce_act, clk_lvl, outs_reg.shift, outs_reg.sop, outs_reg.carry,
		gen_out, q_reg};
	wire [7:0] ra = haddr[7:0];
	wire [31:0] rd_mux = (ra == cls_pkg::OFS_F_TABLE) ? {16'h0000, tab_next[0]} :
		(ra == cls_pkg::OFS_G_TABLE) ? {16'h0000, tab_next[1]} :
		(ra == cls_pkg::OFS_CONFIG) ? {7'h00, cfg_next} :
		(ra == cls_pkg::OFS_STATUS) ? {23'h000000, status} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (addr_ok & ~hwrite) begin
			hrdata_reg <= rd_mux;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign outs = outs_reg;
	assign q_x = q_reg[0];
	assign q_y = q_reg[1];

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	wire no_force = ~frc_act & ~opp_act & ~ginit;

	a_lut_lookup: assert property (
		(xsel == cls_pkg::OSEL_LUT) |=> (outs.x == $past(tab_reg[0][gen_addr[0]])))
		else $error("x output does not match table entry");

	a_five_comb: assert property (
		1'b1 |=> (outs.five == ($past(pin.bypass_in_x) ? $past(gen_out[1]) : $past(gen_out[0]))))
		else $error("five-input combiner picked wrong generator");

	a_shift_tap: assert property (
		(gen_fg[0].sh_en & ~gen_fg[0].bus_wr) |=> (tab_reg[0][0] == $past(pin.shift_in)))
		else $error("shift register did not take chain input");

	a_reset_wins: assert property (
		(~frc_sync & frc_act & opp_act & ~ginit) |=> (q_reg == 2'b00))
		else $error("set won over reset");

	a_force_one: assert property (
		(~frc_sync & frc_act & ~opp_act & fhi[0] & ~ginit) |=> q_x)
		else $error("force to one not applied");

	a_ce_unused: assert property (
		(~ce_used & ~latch_mode & clk_edge & no_force & ~d_sel[0]) |=> (q_x == $past(x_c)))
		else $error("unused clock enable blocked capture");

	a_latch_hold: assert property (
		(latch_mode & ~clk_lvl & no_force) |=> $stable(q_reg))
		else $error("latch changed while closed");

	a_sync_wait: assert property (
		(frc_sync & ~latch_mode & ~clk_edge & ~ginit) |=> $stable(q_reg))
		else $error("synchronous force acted off the edge");

	a_sop_chain: assert property (
		1'b1 |=> (outs.sop == ($past(pin.sop_in) | $past(carry_top))))
		else $error("sum chain or is wrong");

	a_init_load: assert property (
		(wr_ctrl & hwdata[cls_pkg::CTRL_GINIT] & init_follow) |=> (q_reg == $past(fhi)))
		else $error("global init did not load init value");

	c_ram_write: cover property (gen_fg[0].ram_wr);
	c_latch_pass: cover property (latch_mode & clk_lvl & ce_act ##1 $changed(q_x));
	c_carry_and: cover property (pin.carry_in & (&gen_out) ##1 outs.carry);
	c_read_status: cover property (addr_ok & ~hwrite & (ra == cls_pkg::OFS_STATUS));

endmodule

// ===== testbench/test_cls_slice.sv
// self-checking bench for the configurable logic slice
module test_cls_slice;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] FX = 32'h1 << cls_pkg::CFG_FHI_X;
	localparam logic [31:0] LAT = 32'h1 << cls_pkg::CFG_LATCH;
	localparam logic [31:0] CEU = 32'h1 << cls_pkg::CFG_CE_USED;
	localparam logic [31:0] ICE = 32'h1 << cls_pkg::CFG_INV_CE;
	localparam logic [31:0] BYX = 32'h1 << cls_pkg::CFG_BYP_X;
	localparam logic [31:0] OPP = 32'h1 << cls_pkg::CFG_OPP_EN;
	localparam logic [31:0] SYN = 32'h1 << cls_pkg::CFG_SYNC;
	localparam logic [31:0] SHF = 32'(cls_pkg::MODE_SHIFT) << cls_pkg::CFG_F_MODE;
	localparam logic [31:0] SHG = 32'(cls_pkg::MODE_SHIFT) << cls_pkg::CFG_G_MODE;
	localparam logic [31:0] RMF = 32'(cls_pkg::MODE_RAM) << cls_pkg::CFG_F_MODE;
	localparam logic [31:0] W7 = 32'(cls_pkg::WIDE_SEVEN) << cls_pkg::CFG_WIDE;
	localparam logic [31:0] FOL = 32'h1 << cls_pkg::CFG_INIT_FOLLOW;
	localparam logic [15:0] FTAB = 16'h6996;
	localparam logic [15:0] GTAB = 16'h8000;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, q_x, q_y;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	cls_pkg::cls_pins_s pins, p;
	cls_pkg::cls_outs_s outs;
	int n_fail, total_checks;
	assign hready = hreadyout;
	cls_slice i_cls_slice (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pins(pins), .outs(outs), .q_x(q_x), .q_y(q_y));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// pins pass two sync flops and an output flop, so six cycles is ample
	task automatic setp();
		@(posedge hclk);
		pins <= p;
		repeat (6) @(posedge hclk);
	endtask
	task automatic pulse();
		p.slice_clk = 1'b1;
		setp();
		p.slice_clk = 1'b0;
		setp();
	endtask
	task automatic qchk(input logic e);
		chk({31'h0, q_x}, {31'h0, e});
	endtask
	initial begin
		#20000ns;
		n_fail++;
		summarize();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		pins = '0;
		p = '0;
		n_fail = 0;
		total_checks = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(cls_pkg::OFS_CONFIG, 32'h00000100);
		chk({30'h0, hreadyout, hresp}, 32'h00000002);
		rchk(cls_pkg::OFS_F_TABLE, 32'h0);
		xfer(1'b1, 8'h14, 32'hFFFFFFFF);
		rchk(8'h14, 32'h0);
		qchk(1'b0);
		xfer(1'b1, cls_pkg::OFS_F_TABLE, {16'hFFFF, FTAB});
		xfer(1'b1, cls_pkg::OFS_G_TABLE, {16'h0, GTAB});
		rchk(cls_pkg::OFS_F_TABLE, {16'h0, FTAB});
		rchk(cls_pkg::OFS_G_TABLE, {16'h0, GTAB});
		// opposite indices on f and g show the two input sets are separate
		for (int i = 0; i < 16; i++) begin
			p.f_in = 4'(i);
			p.g_in = 4'(15 - i);
			setp();
			chk({31'h0, outs.x}, {31'h0, FTAB[i]});
			chk({31'h0, outs.y}, {31'h0, GTAB[15-i]});
		end
		// g index moved so the two generators disagree
		p.g_in = 4'hF;
		p.bypass_in_x = 1'b1;
		setp();
		chk({31'h0, outs.five}, {31'h0, GTAB[15]});
		p.bypass_in_x = 1'b0;
		setp();
		chk({31'h0, outs.five}, {31'h0, FTAB[15]});
		p.f_in = 4'h1;
		p.g_in = 4'hF;
		p.carry_in = 1'b1;
		setp();
		chk({31'h0, outs.carry}, {31'h0, 1'b1});
		p.carry_in = 1'b0;
		p.sop_in = 1'b1;
		setp();
		chk({31'h0, outs.carry}, {31'h0, 1'b0});
		chk({31'h0, outs.sop}, {31'h0, 1'b1});
		p.sop_in = 1'b0;
		p.bypass_in_y = 1'b1;
		p.fx_in1 = 1'b1;
		setp();
		chk({31'h0, outs.sop}, {31'h0, 1'b0});
		chk({31'h0, outs.wide}, {31'h0, 1'b1});
		p.bypass_in_y = 1'b0;
		setp();
		chk({31'h0, outs.wide}, {31'h0, FTAB[1]});
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | W7);
		setp();
		chk({31'h0, outs.wide}, {31'h0, 1'b0});
		pulse();
		qchk(1'b1);
		p.f_in = 4'h0;
		p.g_in = 4'h0;
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | CEU);
		pulse();
		qchk(1'b1);
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | CEU | ICE);
		pulse();
		qchk(1'b0);
		chk({31'h0, q_y}, {31'h0, GTAB[0]});
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | BYX);
		p.bypass_in_x = 1'b1;
		p.g_in = 4'hF;
		pulse();
		qchk(1'b1);
		chk({31'h0, q_y}, {31'h0, GTAB[15]});
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | LAT);
		p.slice_clk = 1'b1;
		p.f_in = 4'h1;
		setp();
		qchk(1'b1);
		p.f_in = 4'h0;
		setp();
		qchk(1'b0);
		p.slice_clk = 1'b0;
		p.f_in = 4'h1;
		setp();
		qchk(1'b0);
		p.bypass_in_x = 1'b0;
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | FX | OPP);
		p.force_state_in = 1'b1;
		setp();
		qchk(1'b1);
		p.bypass_in_y = 1'b1;
		setp();
		qchk(1'b0);
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | OPP);
		p.force_state_in = 1'b0;
		setp();
		qchk(1'b1);
		p.bypass_in_y = 1'b0;
		p.force_state_in = 1'b1;
		setp();
		qchk(1'b0);
		p.force_state_in = 1'b0;
		setp();
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | FX);
		xfer(1'b1, cls_pkg::OFS_CONTROL, 32'h1);
		repeat (3) @(posedge hclk);
		qchk(1'b1);
		xfer(1'b1, cls_pkg::OFS_CONFIG, FX);
		xfer(1'b1, cls_pkg::OFS_CONTROL, 32'h1);
		repeat (3) @(posedge hclk);
		qchk(1'b0);
		// synchronous force must wait for the slice clock edge
		xfer(1'b1, cls_pkg::OFS_CONFIG, FX | SYN);
		p.force_state_in = 1'b1;
		setp();
		qchk(1'b0);
		pulse();
		qchk(1'b1);
		p.force_state_in = 1'b0;
		p.shift_in = 1'b1;
		setp();
		// one slice clock edge shifts both tables once, f feeding g
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | SHF | SHG);
		chk({31'h0, outs.shift}, {31'h0, GTAB[15]});
		pulse();
		chk({31'h0, outs.shift}, {31'h0, GTAB[14]});
		rchk(cls_pkg::OFS_F_TABLE, {16'h0, FTAB[14:0], 1'b1});
		rchk(cls_pkg::OFS_G_TABLE, {16'h0, GTAB[14:0], FTAB[15]});
		p.ram_we = 1'b1;
		p.f_in = 4'h0;
		xfer(1'b1, cls_pkg::OFS_CONFIG, FOL | RMF);
		pulse();
		rchk(cls_pkg::OFS_F_TABLE, {16'h0, FTAB[14:0], 1'b0});
		summarize();
	end
endmodule
